// ===== logic/rdw_cfg.svh
// Constants of the runaway-detection watchdog: offsets, codes, fields.
// Assumes a 32-bit AHB-Lite slave decode on word addresses.
`ifndef RDW_CFG_SVH
`define RDW_CFG_SVH

// Counter geometry
`define RDW_CNT_W      22
`define RDW_TAP_BASE   15
`define RDW_TAP_STEP   2

// Register word indices (byte address = index * 4)
`define RDW_IDX_MODE   3'h0
`define RDW_IDX_CMD    3'h1
`define RDW_IDX_STAT   3'h2
`define RDW_IDX_IEN    3'h3
`define RDW_IDX_ICLR   3'h4

// Command codes
`define RDW_CODE_DIS   8'hB1
`define RDW_CODE_CLR   8'h4E

// Mode register fields
`define RDW_EN_BIT     7
`define RDW_TSEL_HI    6
`define RDW_TSEL_LO    5
`define RDW_RUNAWAY_RESET_CONTROL_BIT  1

// Status register fields
`define RDW_ST_EVT     0
`define RDW_ST_HELD    1
`define RDW_ST_DIS     2
`define RDW_ST_PEND    3

// Reset values
`define RDW_EN_RST     1'h1
`define RDW_TSEL_RST   2'h0
`define RDW_RUNAWAY_RESET_CONTROL_RST  1'h0
`define RDW_SYNC_RST   1'h1

`endif

// ===== logic/rdw_pkg.sv
// Types of the runaway-detection watchdog.
// Assumes rdw_cfg.svh is on the include path.
`include "rdw_cfg.svh"

package rdw_pkg;

    typedef struct packed {
        logic                  pre;
        logic [`RDW_CNT_W-1:0] cnt;
        logic                  en;
        logic [1:0]            tsel;
        logic                  runaway_reset_control;
        logic                  dis;
        logic                  held;
        logic                  pend;
        logic                  nmi;
        logic                  rst;
        logic                  sts;
        logic                  ien;
        logic                  bus_s1;
        logic                  bus_s2;
        logic                  wr;
        logic                  rd;
        logic [2:0]            idx;
        logic [31:0]           rdata;
    } rdw_state_t;

endpackage

// ===== logic/rdw_watchdog.sv
// Runaway-detection watchdog with AHB-Lite register slave.
// Assumes one clock hclk (taken as the oscillator), a core that services
// the non-maskable runaway pulse, and a low-active bus grant pin.
`timescale 1ns/1ps
`include "rdw_cfg.svh"

module rdw_watchdog #(
    parameter int TAP_BASE = `RDW_TAP_BASE
) (
    // Clock and reset
    input  wire logic        hclk,
    input  wire logic        hresetn,
    // AHB-Lite slave
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output wire logic        hreadyout,
    output wire logic        hresp,
    output wire logic [31:0] hrdata,
    // Power modes, same clock domain
    input  wire logic        deep_idle_mode,
    input  wire logic        light_idle_mode,
    input  wire logic        stop_mode,
    // Bus grant pin, low while the bus is released
    input  wire logic        bus_grant_output_n,
    // Events
    output wire logic        runaway_interrupt,
    output wire logic        internal_reset_req,
    output wire logic        irq
);

    rdw_pkg::rdw_state_t st_q;
    rdw_pkg::rdw_state_t st_d;

    logic                  released;
    logic                  run;
    logic                  tick;
    logic                  det;
    logic                  wr_ok;
    logic                  mode_wr;
    logic                  cmd_wr;
    logic                  addr_ph;
    logic [7:0]            cmd;
    logic [`RDW_CNT_W-1:0] cnt_n;
    int                    tap_i;

    always_comb begin
        st_d = st_q;

        // Second flop is the only reader of the first
        st_d.bus_s1 = bus_grant_output_n;
        st_d.bus_s2 = st_q.bus_s1;
        released    = ~st_q.bus_s2;

        // halted in deep idle and stop
        run = ~st_q.dis & ~deep_idle_mode & ~stop_mode;

        // divide by two, counter steps on alternate clocks
        st_d.pre = ~st_q.pre;
        tick     = st_q.pre & run;
        cnt_n    = st_q.cnt + `RDW_CNT_W'(1);

        // tap bit selected by time field
        tap_i = TAP_BASE + `RDW_TAP_STEP * int'(st_q.tsel);

        // tap rises once per detection period, every 2^(tap_i+1) steps
        det = tick & ~st_q.cnt[tap_i] & cnt_n[tap_i];

        // counting needs no setup after reset
        if (tick) begin
            st_d.cnt = cnt_n;
        end

        wr_ok   = st_q.wr & ~released;
        mode_wr = wr_ok & (st_q.idx == `RDW_IDX_MODE);
        cmd_wr  = wr_ok & (st_q.idx == `RDW_IDX_CMD);
        cmd     = hwdata[7:0];

        if (mode_wr) begin
            st_d.en    = hwdata[`RDW_EN_BIT];
            st_d.tsel  = hwdata[`RDW_TSEL_HI:`RDW_TSEL_LO];
            st_d.runaway_reset_control = hwdata[`RDW_RUNAWAY_RESET_CONTROL_BIT];
            if (hwdata[`RDW_EN_BIT]) begin
                st_d.dis = 1'b0;
            end
        end

        if (cmd_wr) begin
            // disable code accepted only after enable bit cleared
            if (cmd == `RDW_CODE_DIS && !st_q.en) begin
                st_d.dis = 1'b1;
            end
            // clear code zeroes counter, releases held state
            if (cmd == `RDW_CODE_CLR) begin
                st_d.cnt  = '0;
                st_d.held = 1'b0;
            end
            // any other code falls through untouched
        end

        if (wr_ok && st_q.idx == `RDW_IDX_IEN) begin
            st_d.ien = hwdata[`RDW_ST_EVT];
        end
        if (wr_ok && st_q.idx == `RDW_IDX_ICLR && hwdata[`RDW_ST_EVT]) begin
            st_d.sts = 1'b0;
        end

        // pending interrupt waits for the bus to return
        st_d.nmi = 1'b0;
        st_d.rst = 1'b0;
        if (st_q.pend && !released) begin
            st_d.nmi  = 1'b1;
            st_d.pend = 1'b0;
        end

        // Detection is placed last so a same-cycle clear loses
        if (det) begin
            // detected state held until clear code
            st_d.held = 1'b1;
            if (!light_idle_mode) begin
                st_d.pend = 1'b1;
                st_d.sts  = 1'b1;
            end
            if (st_q.runaway_reset_control) begin
                st_d.rst = 1'b1;
            end
        end

        // Address phase capture; zero wait states, so hready is ours
        addr_ph    = hsel & htrans[1] & hready;
        st_d.wr    = addr_ph & hwrite;
        st_d.rd    = addr_ph & ~hwrite;
        st_d.idx   = haddr[4:2];
        st_d.rdata = '0;
        if (addr_ph && !hwrite && !released) begin
            unique case (haddr[4:2])
                `RDW_IDX_MODE: begin
                    st_d.rdata[`RDW_EN_BIT]              = st_q.en;
                    st_d.rdata[`RDW_TSEL_HI:`RDW_TSEL_LO] = st_q.tsel;
                    st_d.rdata[`RDW_RUNAWAY_RESET_CONTROL_BIT]           = st_q.runaway_reset_control;
                end
                `RDW_IDX_STAT: begin
                    st_d.rdata[`RDW_ST_EVT]  = st_q.sts;
                    st_d.rdata[`RDW_ST_HELD] = st_q.held;
                    st_d.rdata[`RDW_ST_DIS]  = st_q.dis;
                    st_d.rdata[`RDW_ST_PEND] = st_q.pend;
                end
                `RDW_IDX_IEN: begin
                    st_d.rdata[`RDW_ST_EVT] = st_q.ien;
                end
                // Command, clear and unmapped words read as zero
                default: begin
                    st_d.rdata = '0;
                end
            endcase
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            st_q        <= '0;
            st_q.en     <= `RDW_EN_RST;
            st_q.tsel   <= `RDW_TSEL_RST;
            st_q.runaway_reset_control  <= `RDW_RUNAWAY_RESET_CONTROL_RST;
            st_q.bus_s1 <= `RDW_SYNC_RST;
            st_q.bus_s2 <= `RDW_SYNC_RST;
        end else begin
            st_q <= st_d;
        end
    end

    assign hreadyout          = 1'b1;
    assign hresp              = 1'b0;
    assign hrdata             = st_q.rdata;
    assign runaway_interrupt  = st_q.nmi;
    assign internal_reset_req = st_q.rst;
    assign irq                = st_q.sts & st_q.ien;

    // Checks on the design's own outputs and state

    default clocking cb @(posedge hclk);
    endclocking

    default disable iff (!hresetn);

    sequence s_en_cleared;
        mode_wr && !hwdata[`RDW_EN_BIT];
    endsequence

    sequence s_dis_code;
        cmd_wr && cmd == `RDW_CODE_DIS;
    endsequence

    sequence s_clr_code;
        cmd_wr && cmd == `RDW_CODE_CLR;
    endsequence

    sequence s_detect_full;
        det && !light_idle_mode && !released;
    endsequence

    property p_two_step;
        // Single transfers with an idle cycle between them land three edges apart
        s_en_cleared ##1 (!mode_wr)[*2] ##1 s_dis_code |=> st_q.dis;
    endproperty

    property p_detect_nmi;
        s_detect_full ##1 !released |=> runaway_interrupt;
    endproperty

    sequence s_reset_out;
        $rose(hresetn);
    endsequence

    a_two_step_dis: assert property (p_two_step)
        else $error("disable sequence did not disable");

    a_dis_needs_clear: assert property (
        $rose(st_q.dis) |-> $past(cmd_wr) && !$past(st_q.en))
        else $error("disabled without enable bit cleared");

    a_reenable_now: assert property (
        mode_wr && hwdata[`RDW_EN_BIT] |=> !st_q.dis && st_q.en)
        else $error("enable bit write did not re-enable");

    // A detection in the same cycle keeps the held state: set wins
    a_clear_count: assert property (
        s_clr_code ##0 !det |=> st_q.cnt == '0 && !st_q.held)
        else $error("clear code did not zero the counter");

    a_other_code: assert property (
        cmd_wr && cmd != `RDW_CODE_DIS && cmd != `RDW_CODE_CLR
        |=> st_q.dis == $past(st_q.dis) && st_q.en == $past(st_q.en))
        else $error("stray command changed state");

    a_detect_nmi: assert property (p_detect_nmi)
        else $error("runaway interrupt missing after detection");

    a_light_quiet: assert property (
        det && light_idle_mode && !st_q.pend |=> ##1 !runaway_interrupt)
        else $error("runaway interrupt raised in light idle");

    a_bus_hold: assert property (
        released && st_q.pend |=> !runaway_interrupt ##0 st_q.pend)
        else $error("interrupt issued during bus release");

    a_bus_block: assert property (
        st_q.wr && released |=> $stable(st_q.en) && $stable(st_q.tsel))
        else $error("register written during bus release");

    a_read_blocked: assert property (
        released && addr_ph && !hwrite |=> hrdata == 32'h0000_0000)
        else $error("register read during bus release");

    a_halt_modes: assert property (
        (deep_idle_mode || stop_mode) && !cmd_wr |=> $stable(st_q.cnt))
        else $error("counter moved in deep idle or stop");

    // Disabled counter is frozen, not reset, so it resumes where it stopped
    a_dis_freeze: assert property (
        st_q.dis && !cmd_wr |=> $stable(st_q.cnt))
        else $error("counter moved while disabled");

    // A clear code may land on a step, so it is left out here
    a_step_rate: assert property (
        tick && !(cmd_wr && cmd == `RDW_CODE_CLR)
        |=> !tick ##0 st_q.cnt == $past(st_q.cnt) + `RDW_CNT_W'(1))
        else $error("counter stepped faster than half rate");

    a_self_reset: assert property (
        det && st_q.runaway_reset_control |=> internal_reset_req)
        else $error("forced reset missing");

    // Steps come every other clock, so two detections never touch
    a_reset_one: assert property (
        internal_reset_req |=> !internal_reset_req)
        else $error("forced reset longer than one cycle");

    a_no_reset: assert property (
        !st_q.runaway_reset_control |=> !internal_reset_req)
        else $error("reset forced with reset control clear");

    a_held_state: assert property (
        st_q.held && !(cmd_wr && cmd == `RDW_CODE_CLR) |=> st_q.held)
        else $error("held state dropped without clear code");

    a_reset_vals: assert property (
        s_reset_out |-> st_q.en == `RDW_EN_RST)
        else $error("enable bit wrong after reset");

    a_tsel_reset: assert property (
        s_reset_out |-> st_q.tsel == `RDW_TSEL_RST)
        else $error("time field wrong after reset");

    a_runaway_reset_control_reset: assert property (
        s_reset_out |-> st_q.runaway_reset_control == `RDW_RUNAWAY_RESET_CONTROL_RST)
        else $error("reset control wrong after reset");

    // Counting needs no setup: the first step follows one edge after release
    a_count_start: assert property (
        s_reset_out ##1 (!deep_idle_mode && !stop_mode) |-> tick)
        else $error("counter did not start after reset");

    // Status set wins over a clear written in the same cycle
    a_irq_level: assert property (
        det && !light_idle_mode |=> st_q.sts ##0 irq == st_q.ien)
        else $error("runaway status not set or interrupt level wrong");

    a_iclr_clear: assert property (
        wr_ok && st_q.idx == `RDW_IDX_ICLR && hwdata[`RDW_ST_EVT] && !det
        |=> !st_q.sts)
        else $error("status clear write had no effect");

endmodule

// ===== verif/rdw_core_model.sv
// Core side of the watchdog: records runaway and forced-reset pulses.
// Assumes pulses are one hclk wide and registered in the watchdog.
`timescale 1ns/1ps

module rdw_core_model (
    // Clock and reset
    input  wire logic hclk,
    input  wire logic hresetn,
    // Events from the watchdog
    input  wire logic runaway_interrupt,
    input  wire logic internal_reset_req,
    // Service record
    output int        nmi_count,
    output int        rst_count,
    output int        last_gap
);
    int since;

    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            nmi_count <= 0;
            rst_count <= 0;
            last_gap  <= 0;
            since     <= 0;
        end else begin
            since <= since + 1;
            if (runaway_interrupt === 1'b1) begin
                nmi_count <= nmi_count + 1;
                last_gap  <= since + 1;
                since     <= 0;
            end
            if (internal_reset_req === 1'b1) begin
                rst_count <= rst_count + 1;
            end
        end
    end
endmodule

// ===== verif/test_runaway_detection_watchdog.sv
// Register-level test of the watchdog over AHB-Lite.
// Assumes a short tap base so every period fits in a short run.
`timescale 1ns/1ps
`include "rdw_cfg.svh"

module test_runaway_detection_watchdog;
    localparam int TB = 2;
    logic        hclk, hresetn, hsel, hwrite, dmode, lmode, smode, bus_n;
    logic [31:0] haddr, hwdata, hrdata, rd;
    logic [1:0]  htrans;
    logic        hreadyout, hresp, nmi, rreq, irq;
    int          nmi_count, rst_count, last_gap, bad_count, check_count, cyc;

    rdw_watchdog #(.TAP_BASE(TB)) DUT (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
        .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
        .deep_idle_mode(dmode), .light_idle_mode(lmode), .stop_mode(smode),
        .bus_grant_output_n(bus_n), .runaway_interrupt(nmi),
        .internal_reset_req(rreq), .irq(irq));

    rdw_core_model core (
        .hclk(hclk), .hresetn(hresetn), .runaway_interrupt(nmi),
        .internal_reset_req(rreq), .nmi_count(nmi_count), .rst_count(rst_count),
        .last_gap(last_gap));

    task automatic end_sim();
        $display("checks %0d mismatches %0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        check_count++;
        if (g !== e) begin
            bad_count++;
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
        end
    endtask

    // Address phase held until hready, then data phase held until hready
    task automatic xfer(input logic wr, input logic [2:0] idx, input logic [31:0] d);
        @(posedge hclk);
        hsel   <= 1'b1;
        htrans <= 2'b10;
        hwrite <= wr;
        haddr  <= {27'h000_0000, idx, 2'b00};
        do @(posedge hclk); while (hreadyout !== 1'b1);
        hsel   <= 1'b0;
        htrans <= 2'b00;
        hwdata <= d;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        rd = hrdata;
        chk("hresp", 32'h0000_0000, {31'h0, hresp});
    endtask

    task automatic wait_nmi(input int lim);
        int n0;
        int k;
        n0 = nmi_count;
        k = 0;
        while (nmi_count == n0 && k < lim) begin
            @(posedge hclk);
            k++;
        end
        chk("runaway pulse seen", 32'h0000_0001, {31'h0, nmi_count != n0});
    endtask

    // Lets a pulse already in flight land before counting
    task automatic quiet(input int n, input string nm);
        int n0;
        repeat (3) @(posedge hclk);
        n0 = nmi_count;
        repeat (n) @(posedge hclk);
        chk(nm, n0, nmi_count);
    endtask

    initial begin
        hclk = 1'b0;
        forever #2 hclk = ~hclk;
    end

    always @(posedge hclk) begin
        cyc++;
        if (cyc == 20000) begin
            bad_count++;
            end_sim();
        end
    end

    initial begin
        {hresetn, hsel, hwrite, dmode, lmode, smode} = '0;
        {haddr, hwdata, htrans, rd, bad_count, check_count} = '0;
        bus_n = 1'b1;
        repeat (6) @(posedge hclk);
        hresetn <= 1'b1;
        wait_nmi(30);
        xfer(1'b0, `RDW_IDX_MODE, 0);
        chk("mode reset", 32'h0000_0080, rd);
        xfer(1'b0, 3'h5, 0);
        chk("unmapped read", 32'h0000_0000, rd);
        $display("test reset done");
        for (int t = 0; t < 4; t++) begin
            xfer(1'b1, `RDW_IDX_MODE, 32'h0000_0080 | (t << 5));
            wait_nmi(2 ** (TB + 3 + 2 * t));
            wait_nmi(2 ** (TB + 3 + 2 * t));
            chk("pulse gap", 2 ** (TB + 2 + 2 * t), last_gap);
        end
        xfer(1'b1, `RDW_IDX_MODE, 32'h0000_0080);
        $display("test periods done");
        xfer(1'b1, `RDW_IDX_CMD, {24'h00_0000, `RDW_CODE_CLR});
        fork
            repeat (25) xfer(1'b1, `RDW_IDX_CMD, {24'h00_0000, `RDW_CODE_CLR});
            quiet(40, "clear holds off");
        join
        xfer(1'b1, `RDW_IDX_MODE, 32'h0000_0082);
        repeat (30) @(posedge hclk);
        chk("forced reset", 32'h0000_0001, {31'h0, rst_count > 0});
        xfer(1'b0, `RDW_IDX_STAT, 0);
        chk("held state", 32'h0000_0002, rd & 32'h0000_0002);
        xfer(1'b1, `RDW_IDX_MODE, 32'h0000_0080);
        $display("test clear and reset done");
        xfer(1'b1, `RDW_IDX_IEN, 32'h0000_0001);
        wait_nmi(30);
        repeat (2) @(posedge hclk);
        chk("irq level", 32'h0000_0001, {31'h0, irq});
        xfer(1'b1, `RDW_IDX_CMD, {24'h00_0000, `RDW_CODE_DIS});
        xfer(1'b0, `RDW_IDX_STAT, 0);
        chk("disable wrong order", 32'h0000_0000, rd & 32'h0000_0004);
        xfer(1'b1, `RDW_IDX_MODE, 32'h0000_0000);
        xfer(1'b1, `RDW_IDX_CMD, {24'h00_0000, `RDW_CODE_DIS});
        xfer(1'b1, `RDW_IDX_ICLR, 32'h0000_0001);
        xfer(1'b1, `RDW_IDX_CMD, 32'h0000_0055);
        xfer(1'b0, `RDW_IDX_STAT, 0);
        chk("disabled status", 32'h0000_0004, rd & 32'h0000_0005);
        chk("irq cleared", 32'h0000_0000, {31'h0, irq});
        quiet(40, "disabled quiet");
        xfer(1'b1, `RDW_IDX_MODE, 32'h0000_0080);
        wait_nmi(40);
        $display("test disable done");
        dmode <= 1'b1;
        quiet(60, "deep idle halt");
        dmode <= 1'b0;
        smode <= 1'b1;
        quiet(60, "stop halt");
        xfer(1'b1, `RDW_IDX_CMD, {24'h00_0000, `RDW_CODE_CLR});
        smode <= 1'b0;
        lmode <= 1'b1;
        quiet(60, "light idle silent");
        xfer(1'b0, `RDW_IDX_STAT, 0);
        chk("light idle counts", 32'h0000_0002, rd & 32'h0000_0002);
        lmode <= 1'b0;
        wait_nmi(40);
        $display("test modes done");
        bus_n <= 1'b0;
        fork
            quiet(40, "release holds pulse");
            begin
                repeat (4) @(posedge hclk);
                xfer(1'b1, `RDW_IDX_MODE, 32'h0000_0000);
                xfer(1'b0, `RDW_IDX_MODE, 0);
                chk("released read", 32'h0000_0000, rd);
            end
        join
        bus_n <= 1'b1;
        wait_nmi(8);
        xfer(1'b0, `RDW_IDX_MODE, 0);
        chk("released write", 32'h0000_0080, rd);
        $display("test bus release done");
        end_sim();
    end
endmodule
